// file: rtl/obl_cfg.svh
/*
 Constants of the option byte loader: bus offsets, option byte field
 positions, reset values and settling counts.
 Assumes a 32-bit APB with byte addresses and an 8-bit flash read port.
*/
`ifndef OBL_CFG_SVH
`define OBL_CFG_SVH

`define OBL_FLASH_AW        16
`define OBL_OPT_ADDR        16'h0080

`define OBL_REG_SLOW_MODE   8'h00
`define OBL_REG_WDT_SEL     8'h04
`define OBL_REG_STATUS      8'h08
`define OBL_REG_OPT_BYTE    8'h80

`define OBL_BIT_FIX7        7
`define OBL_BIT_SETTLE_HI   6
`define OBL_BIT_SETTLE_LO   5
`define OBL_BIT_FIX4        4
`define OBL_BIT_RST_FUNC    3
`define OBL_BIT_CLK_HI      2
`define OBL_BIT_CLK_LO      1
`define OBL_BIT_SLOW_LOCK   0

`define OBL_OPT_RESET       8'h00
`define OBL_SETTLE_CNT_00   1024
`define OBL_SETTLE_CNT_01   4096
`define OBL_SETTLE_CNT_10   32768
`define OBL_SETTLE_CNT_11   131072
`define OBL_SETTLE_CW       18

`endif

// file: rtl/obl_loader.sv
/*
 Option byte loader: fetches the boot option byte after reset, decodes it
 and drives clock source, pin sharing, settling, reset pin and slow
 oscillator / watchdog clock controls. APB slave for status and control.
 Assumes a flash read port answering with rvalid, synchronous inputs, and
 an osc_tick strobe per main oscillator cycle.
*/
`timescale 1ns/100ps
`include "obl_cfg.svh"
module obl_loader #(
    parameter int SETTLE_CNT_00 = `OBL_SETTLE_CNT_00,
    parameter int SETTLE_CNT_01 = `OBL_SETTLE_CNT_01,
    parameter int SETTLE_CNT_10 = `OBL_SETTLE_CNT_10,
    parameter int SETTLE_CNT_11 = `OBL_SETTLE_CNT_11
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic                          flash_rd,
    output logic      [`OBL_FLASH_AW-1:0] flash_addr,
    input  wire logic [7:0]               flash_rdata,
    input  wire logic                     flash_rvalid,
    input  wire logic                     osc_tick,
    input  wire logic                     reset_pin_n,
    input  wire logic                     halt_mode,
    input  wire logic                     stop_mode,
    output logic                          cpu_run,
    output logic [1:0]                    clk_src,
    output logic                          osc_in_clk_en,
    output logic                          osc_out_clk_en,
    output logic                          osc_in_port_en,
    output logic                          osc_out_port_en,
    output logic                          reset_pin_is_port,
    output logic                          reset_shared_input_bit,
    output logic                          slow_osc_run,
    output logic                          wdt_clk_is_slow,
    output logic                          wdt_clk_en,
    output logic                          aux_timer_clk_en
);
    obl_pkg::obl_state_t   state_q;
    obl_pkg::obl_clk_src_t src_d;
    logic [7:0]            opt_q;
    logic                  cfg_valid_q;
    logic                  fmt_err_q;
    logic                  slow_stop_q;
    logic                  wdt_sel_other_q;
    logic [31:0]           prdata_q;
    logic                  pready_q;
    logic                  pslverr_q;
    logic                  flash_rd_q;
    logic                  run_q;
    logic [1:0]            clk_src_q;
    logic                  osc_in_clk_q;
    logic                  osc_out_clk_q;
    logic                  osc_in_port_q;
    logic                  osc_out_port_q;
    logic                  rst_port_q;
    logic                  rst_in_bit_q;
    logic                  slow_run_q;
    logic                  wdt_slow_q;
    logic                  wdt_en_q;
    logic                  aux_en_q;
    logic                  lock;
    logic                  rst_func;
    logic                  slow_run_d;
    obl_settle_if          sif ();

    function automatic obl_pkg::obl_clk_src_t decode_src(input logic [1:0] f);
        if (f[1])
            decode_src = obl_pkg::CS_HIOSC;
        else if (f[0])
            decode_src = obl_pkg::CS_EXT;
        else
            decode_src = obl_pkg::CS_XTAL;
    endfunction

    obl_settle_timer #(
        .CNT_00 (SETTLE_CNT_00),
        .CNT_01 (SETTLE_CNT_01),
        .CNT_10 (SETTLE_CNT_10),
        .CNT_11 (SETTLE_CNT_11)
    ) u_settle (
        .pclk     (pclk),
        .presetn  (presetn),
        .osc_tick (osc_tick),
        .tif      (sif.tmr)
    );

    assign lock     = opt_q[`OBL_BIT_SLOW_LOCK];
    assign rst_func = opt_q[`OBL_BIT_RST_FUNC];
    assign src_d    = decode_src(opt_q[`OBL_BIT_CLK_HI:`OBL_BIT_CLK_LO]);

    // fetch sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= obl_pkg::ST_FETCH;
            opt_q       <= `OBL_OPT_RESET;
            cfg_valid_q <= 1'b0;
            fmt_err_q   <= 1'b0;
            flash_rd_q  <= 1'b0;
            sif.start   <= 1'b0;
            sif.sel     <= 2'b00;
        end else begin
            flash_rd_q <= 1'b0;
            sif.start  <= 1'b0;
            unique case (state_q)
                obl_pkg::ST_FETCH: begin
                    if (reset_pin_n) begin
                        flash_rd_q <= 1'b1;
                        state_q    <= obl_pkg::ST_WAIT;
                    end
                end
                obl_pkg::ST_WAIT: begin
                    if (!reset_pin_n) begin
                        state_q <= obl_pkg::ST_FETCH;
                    end else if (flash_rvalid) begin
                        opt_q       <= flash_rdata;
                        cfg_valid_q <= 1'b1;
                        fmt_err_q   <= !(flash_rdata[`OBL_BIT_FIX7]
                                         && flash_rdata[`OBL_BIT_FIX4]);
                        if (decode_src(flash_rdata[`OBL_BIT_CLK_HI:`OBL_BIT_CLK_LO])
                                == obl_pkg::CS_XTAL) begin
                            sif.start <= 1'b1;
                            sif.sel   <= flash_rdata[`OBL_BIT_SETTLE_HI:`OBL_BIT_SETTLE_LO];
                            state_q   <= obl_pkg::ST_SETTLE;
                        end else begin
                            state_q <= obl_pkg::ST_RUN;
                        end
                    end
                end
                obl_pkg::ST_SETTLE: begin
                    if (sif.done)
                        state_q <= obl_pkg::ST_RUN;
                end
                obl_pkg::ST_RUN: begin
                    if (rst_func && !reset_pin_n) begin
                        state_q     <= obl_pkg::ST_FETCH;
                        cfg_valid_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // software control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_stop_q     <= 1'b0;
            wdt_sel_other_q <= 1'b0;
        end else if (psel && penable && pready_q && pwrite && !pslverr_q) begin
            if (paddr == `OBL_REG_SLOW_MODE)
                slow_stop_q <= pwdata[0] && !lock;
            if (paddr == `OBL_REG_WDT_SEL)
                wdt_sel_other_q <= pwdata[0];
        end
    end

    // apb slave: answer prepared in setup, one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            pready_q  <= 1'b1;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            unique case (paddr)
                `OBL_REG_SLOW_MODE: prdata_q[0]   <= slow_stop_q;
                `OBL_REG_WDT_SEL:   prdata_q[0]   <= wdt_sel_other_q;
                `OBL_REG_STATUS:    prdata_q[4:0] <= {fmt_err_q, cfg_valid_q,
                                                      state_q, slow_run_q};
                `OBL_REG_OPT_BYTE:  prdata_q[7:0] <= pwrite ? 8'h00 : opt_q;
                default:            pslverr_q     <= 1'b1;
            endcase
            if (pwrite && (paddr == `OBL_REG_STATUS || paddr == `OBL_REG_OPT_BYTE))
                pslverr_q <= 1'b1;
        end else if (psel && penable && pready_q) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign slow_run_d = !cfg_valid_q || lock || !slow_stop_q;

    // decoded controls: clock source and clock enables live once configured, cpu run, port and reset pin controls only in ST_RUN
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q          <= 1'b0;
            clk_src_q      <= 2'b00;
            osc_in_clk_q   <= 1'b0;
            osc_out_clk_q  <= 1'b0;
            osc_in_port_q  <= 1'b0;
            osc_out_port_q <= 1'b0;
            rst_port_q     <= 1'b0;
            rst_in_bit_q   <= 1'b0;
        end else begin
            run_q          <= (state_q == obl_pkg::ST_RUN) && cfg_valid_q
                              && !(rst_func && !reset_pin_n);
            clk_src_q      <= cfg_valid_q ? 2'(src_d) : 2'b00;
            osc_in_clk_q   <= cfg_valid_q && src_d != obl_pkg::CS_HIOSC;
            osc_out_clk_q  <= cfg_valid_q && src_d == obl_pkg::CS_XTAL;
            osc_in_port_q  <= (state_q == obl_pkg::ST_RUN)
                              && src_d == obl_pkg::CS_HIOSC;
            osc_out_port_q <= (state_q == obl_pkg::ST_RUN)
                              && src_d != obl_pkg::CS_XTAL;
            rst_port_q     <= (state_q == obl_pkg::ST_RUN) && !rst_func;
            rst_in_bit_q   <= (state_q == obl_pkg::ST_RUN) && !rst_func
                              && reset_pin_n;
        end
    end

    // slow oscillator, watchdog and auxiliary timer clocking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_run_q <= 1'b1;
            wdt_slow_q <= 1'b1;
            wdt_en_q   <= 1'b0;
            aux_en_q   <= 1'b0;
        end else begin
            slow_run_q <= slow_run_d;
            wdt_slow_q <= !cfg_valid_q || lock || !wdt_sel_other_q;
            if (!cfg_valid_q)
                wdt_en_q <= 1'b0;
            else if (lock)
                wdt_en_q <= 1'b1;
            else
                wdt_en_q <= !halt_mode && !stop_mode && !wdt_sel_other_q
                            && slow_run_d;
            aux_en_q   <= cfg_valid_q && slow_run_d;
        end
    end

    assign prdata                 = prdata_q;
    assign pready                 = pready_q;
    assign pslverr                = pslverr_q;
    assign flash_rd               = flash_rd_q;
    assign flash_addr             = `OBL_OPT_ADDR;
    assign cpu_run                = run_q;
    assign clk_src                = clk_src_q;
    assign osc_in_clk_en          = osc_in_clk_q;
    assign osc_out_clk_en         = osc_out_clk_q;
    assign osc_in_port_en         = osc_in_port_q;
    assign osc_out_port_en        = osc_out_port_q;
    assign reset_pin_is_port      = rst_port_q;
    assign reset_shared_input_bit = rst_in_bit_q;
    assign slow_osc_run           = slow_run_q;
    assign wdt_clk_is_slow        = wdt_slow_q;
    assign wdt_clk_en             = wdt_en_q;
    assign aux_timer_clk_en       = aux_en_q;

    chk_run_after_fetch: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_run |-> cfg_valid_q)
        else $error("cpu released before option byte fetched");
    chk_fetch_address: assert property (@(posedge pclk) disable iff (!presetn)
        flash_rd |-> flash_addr == `OBL_OPT_ADDR)
        else $error("option byte read at wrong address");
    chk_settle_xtal_only: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == obl_pkg::ST_SETTLE |-> src_d == obl_pkg::CS_XTAL)
        else $error("settling wait with non crystal source");
    chk_no_wait_other: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == obl_pkg::ST_WAIT && reset_pin_n && flash_rvalid && flash_rdata[2])
        |=> state_q == obl_pkg::ST_RUN ##1 cpu_run)
        else $error("internal source did not start at once");
    chk_pin_low_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (!reset_pin_n && state_q == obl_pkg::ST_FETCH) |=> !flash_rd && !cpu_run)
        else $error("left reset with reset pin low");
    chk_reset_port_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (cpu_run && $stable(opt_q)) |-> reset_pin_is_port == !rst_func)
        else $error("reset pin function not as configured");
    chk_xtal_pins_held: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_valid_q && src_d == obl_pkg::CS_XTAL) |=> !osc_in_port_en && !osc_out_port_en)
        else $error("crystal pin used as port");
    chk_lock_forces_wdt: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_valid_q && lock) |=> wdt_clk_is_slow && slow_osc_run && wdt_clk_en)
        else $error("locked slow oscillator not clocking watchdog");
    chk_wdt_gate_halt: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_valid_q && !lock && (halt_mode || stop_mode)) |=> !wdt_clk_en)
        else $error("watchdog clocked in halt or stop");
    chk_aux_in_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_valid_q && stop_mode && !slow_stop_q) |=> aux_timer_clk_en)
        else $error("auxiliary timer clock lost in stop");
endmodule

// file: rtl/obl_pkg.sv
/*
 Types of the option byte loader.
 Assumes obl_cfg.svh holds every numeric constant.
*/
package obl_pkg;
    typedef enum logic [1:0] {
        ST_FETCH,
        ST_WAIT,
        ST_SETTLE,
        ST_RUN
    } obl_state_t;

    typedef enum logic [1:0] {
        CS_XTAL,
        CS_EXT,
        CS_HIOSC
    } obl_clk_src_t;
endpackage

// file: rtl/obl_settle_if.sv
/*
 Link between the loader sequencer and its settling timer.
 Assumes both ends run on pclk.
*/
`timescale 1ns/100ps
interface obl_settle_if;
    logic       start;
    logic [1:0] sel;
    logic       busy;
    logic       done;

    modport ctl (output start, output sel, input busy, input done);
    modport tmr (input start, input sel, output busy, output done);
endinterface

// file: rtl/obl_settle_timer.sv
/*
 Oscillator settling timer: counts main oscillator cycles after a start.
 Assumes osc_tick is a one-pclk strobe per main oscillator cycle.
*/
`timescale 1ns/100ps
`include "obl_cfg.svh"
module obl_settle_timer #(
    parameter int CNT_00 = `OBL_SETTLE_CNT_00,
    parameter int CNT_01 = `OBL_SETTLE_CNT_01,
    parameter int CNT_10 = `OBL_SETTLE_CNT_10,
    parameter int CNT_11 = `OBL_SETTLE_CNT_11
) (
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   osc_tick,
    obl_settle_if.tmr   tif
);
    logic [`OBL_SETTLE_CW-1:0] cnt_q;
    logic [`OBL_SETTLE_CW-1:0] target_q;
    logic                      busy_q;
    logic                      done_q;

    function automatic logic [`OBL_SETTLE_CW-1:0] last_of(input logic [1:0] s);
        unique case (s)
            2'b00: last_of = `OBL_SETTLE_CW'(CNT_00 - 1);
            2'b01: last_of = `OBL_SETTLE_CW'(CNT_01 - 1);
            2'b10: last_of = `OBL_SETTLE_CW'(CNT_10 - 1);
            2'b11: last_of = `OBL_SETTLE_CW'(CNT_11 - 1);
        endcase
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q    <= '0;
            target_q <= '0;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (tif.start) begin
                cnt_q    <= '0;
                target_q <= last_of(tif.sel);
                busy_q   <= 1'b1;
            end else if (busy_q && osc_tick) begin
                if (cnt_q == target_q) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    assign tif.busy = busy_q;
    assign tif.done = done_q;

    chk_settle_end_count: assert property (@(posedge pclk) disable iff (!presetn)
        (busy_q && !tif.start && osc_tick && cnt_q == target_q) |=> (done_q && !busy_q))
        else $error("settling wait did not end at its count");
endmodule

// file: tb/obl_flash_model.sv
/*
 Flash model holding the option byte: answers each read after lat + 1 cycles.
 Assumes pclk domain and a one-cycle read strobe from the loader.
*/
`timescale 1ns/100ps
`include "obl_cfg.svh"
module obl_flash_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        flash_rd,
    input  wire logic [15:0] flash_addr,
    input  wire logic [7:0]  opt_byte,
    input  wire logic [3:0]  lat,
    output logic      [7:0]  flash_rdata,
    output logic             flash_rvalid,
    output logic             addr_ok
);
    logic [3:0] cnt_q;
    logic       busy_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q       <= 1'b0;
            cnt_q        <= 4'h0;
            flash_rvalid <= 1'b0;
            flash_rdata  <= 8'hA5;
            addr_ok      <= 1'b0;
        end else begin
            flash_rvalid <= 1'b0;
            // data lines invert every cycle outside the answer cycle, so the last byte reappears every other cycle
            flash_rdata  <= ~flash_rdata;
            if (flash_rd) begin
                busy_q  <= 1'b1;
                cnt_q   <= lat;
                addr_ok <= (flash_addr == `OBL_OPT_ADDR);
            end else if (busy_q) begin
                if (cnt_q == 4'h0) begin
                    busy_q       <= 1'b0;
                    flash_rvalid <= 1'b1;
                    flash_rdata  <= opt_byte;
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
            end
        end
    end
endmodule

// file: tb/tb_obl_loader.sv
/*
 Testbench of the option byte loader: boots it with many option bytes and
 checks decode, settling, pin sharing, slow oscillator and watchdog control.
 Assumes the flash model in tb/ and rtl/ on the include path.
*/
`timescale 1ns/100ps
`include "obl_cfg.svh"
module tb_obl_loader;
    localparam int CNT [4] = '{4, 8, 16, 32};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, opt_byte = 8'h91, flash_rdata, ob;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, perr, flash_rd, flash_rvalid, addr_ok;
    logic [15:0] flash_addr;
    logic [3:0]  lat = 4'h0;
    logic        osc_tick = 1'b0, reset_pin_n = 1'b1, halt_mode = 1'b0, stop_mode = 1'b0;
    logic        cpu_run, osc_in_clk_en, osc_out_clk_en, osc_in_port_en, osc_out_port_en;
    logic        reset_pin_is_port, reset_shared_input_bit, slow_osc_run;
    logic        wdt_clk_is_slow, wdt_clk_en, aux_timer_clk_en;
    logic [1:0]  clk_src;
    int          num_errors = 0, checks_done = 0;

    obl_loader #(.SETTLE_CNT_00(CNT[0]), .SETTLE_CNT_01(CNT[1]),
                 .SETTLE_CNT_10(CNT[2]), .SETTLE_CNT_11(CNT[3])) i_obl_loader (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
        .flash_rvalid(flash_rvalid), .osc_tick(osc_tick), .reset_pin_n(reset_pin_n),
        .halt_mode(halt_mode), .stop_mode(stop_mode), .cpu_run(cpu_run), .clk_src(clk_src),
        .osc_in_clk_en(osc_in_clk_en), .osc_out_clk_en(osc_out_clk_en),
        .osc_in_port_en(osc_in_port_en), .osc_out_port_en(osc_out_port_en),
        .reset_pin_is_port(reset_pin_is_port), .reset_shared_input_bit(reset_shared_input_bit),
        .slow_osc_run(slow_osc_run), .wdt_clk_is_slow(wdt_clk_is_slow),
        .wdt_clk_en(wdt_clk_en), .aux_timer_clk_en(aux_timer_clk_en));

    obl_flash_model i_obl_flash_model (
        .pclk(pclk), .presetn(presetn), .flash_rd(flash_rd), .flash_addr(flash_addr),
        .opt_byte(opt_byte), .lat(lat), .flash_rdata(flash_rdata),
        .flash_rvalid(flash_rvalid), .addr_ok(addr_ok));

    initial begin
        forever #20 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // clock source, in clock, out clock, in port, out port
    function automatic logic [5:0] exp_pins(input logic [7:0] b);
        logic xtal;
        xtal = (b[2:1] == 2'h0);
        exp_pins = {b[2] ? 2'h2 : {1'b0, b[1]}, !b[2], xtal, b[2], !xtal};
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never re-drives psel in this step
        @(posedge pclk);
    endtask

    task automatic boot(input logic [7:0] b, input logic [3:0] l, input logic hold);
        int cyc, at, ticks;
        logic seen;
        cyc = 0;
        at = 0;
        ticks = 0;
        seen = 1'b0;
        opt_byte <= b;
        lat <= l;
        presetn <= 1'b0;
        reset_pin_n <= !hold;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        while (cpu_run !== 1'b1 && cyc < 400) begin
            osc_tick <= 1'($urandom_range(1, 0));
            @(posedge pclk);
            cyc++;
            if (seen && osc_tick) ticks++;
            if (!seen && flash_rvalid === 1'b1) begin
                seen = 1'b1;
                at = cyc;
            end
            if (hold && cyc == 20) begin
                check({cpu_run, seen}, 2'h0);
                reset_pin_n <= 1'b1;
            end
        end
        osc_tick <= 1'b0;
        check({cpu_run, seen, addr_ok}, 3'h7);
        if (b[2:1] == 2'h0) begin
            check(ticks >= CNT[b[6:5]] - 1 && ticks <= CNT[b[6:5]] + 4, 1'b1);
        end else begin
            check(cyc - at <= 5, 1'b1);
        end
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        final_report();
    end

    initial begin
        void'($urandom(32'hFE2A));
        for (int i = 0; i < 16; i++) begin
            ob = 8'($urandom);
            ob[7] = (i != 5);
            ob[4] = 1'b1;
            ob[2:1] = 2'(i);
            ob[6:5] = 2'(i >> 2);
            boot(ob, 4'($urandom_range(3, 0)), 1'b0);
            repeat (2) @(posedge pclk);
            check({clk_src, osc_in_clk_en, osc_out_clk_en, osc_in_port_en, osc_out_port_en},
                  exp_pins(ob));
            check({reset_pin_is_port, reset_shared_input_bit}, {2{!ob[3]}});
            opt_byte <= ~ob;
            apb(1'b0, 8'h80, 32'h0);
            check(rdat, {24'h0, ob});
            apb(1'b0, 8'h08, 32'h0);
            check(rdat[4:1], {!(ob[7] && ob[4]), 1'b1, 2'h3});
            apb(1'b1, 8'h00, 32'h1);
            repeat (3) @(posedge pclk);
            check(slow_osc_run, ob[0]);
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h04, 32'h1);
            repeat (3) @(posedge pclk);
            if (ob[0]) check(wdt_clk_is_slow, 1'b1);
            else check(wdt_clk_en, 1'b0);
            apb(1'b1, 8'h04, 32'h0);
            halt_mode <= i[0];
            stop_mode <= !i[0];
            repeat (3) @(posedge pclk);
            if (!ob[0]) check(wdt_clk_en, 1'b0);
            if (!i[0]) check(aux_timer_clk_en, 1'b1);
            halt_mode <= 1'b0;
            stop_mode <= 1'b0;
            // pin low: a port bit reading low, or a fresh reset holding the cpu
            reset_pin_n <= 1'b0;
            repeat (3) @(posedge pclk);
            check({reset_shared_input_bit, cpu_run}, {1'b0, !ob[3]});
            reset_pin_n <= 1'b1;
            if (i == 0) begin
                apb(1'b1, 8'h80, 32'hFF);
                check(perr, 1'b1);
                apb(1'b0, 8'h3C, 32'h0);
                check({perr, rdat}, {1'b1, 32'h0});
            end
            @(posedge pclk);
        end
        boot(8'h91, 4'h2, 1'b1);
        final_report();
    end
endmodule
